// *** shared/lbc_regs.svh ***
// Constants for the local bus controller: spaces, lane widths, timing
`ifndef LBC_REGS_SVH
`define LBC_REGS_SVH

// Space code, taken from local address bits 22..20
`define LBC_SP_LSB      20
`define LBC_SP_ROM      3'h0
`define LBC_SP_IO       3'h1
`define LBC_SP_EXT      3'h2
`define LBC_SP_PCI      3'h3

// Local bus data lane width in bits
`define LBC_LANE_W      16

// Timing in local clock edges
`define LBC_RD_STB_AT   3'h2
`define LBC_WR_DATA_AT  3'h2
`define LBC_WR_STB_AT   3'h3
`define LBC_ROM_WAIT    3'h5
`define LBC_IO_WAIT     3'h7
`define LBC_IO_RECOV    3'h7

// Time-over in ns, and the system clock period in ns
`define LBC_TOUT_NS     8000
`define LBC_CLK_NS      40

// Reset values
`define LBC_IRQ_RST     1'b1

`endif

// *** shared/lbc_pkg.sv ***
// Types for the local bus controller
`default_nettype none
package lbc_pkg;

  typedef enum logic [1:0] {
    SZ_8  = 2'b00,
    SZ_16 = 2'b01,
    SZ_32 = 2'b10,
    SZ_64 = 2'b11
  } lbc_size_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WGRANT = 3'b001,
    ST_SETUP  = 3'b010,
    ST_STROBE = 3'b011,
    ST_RGRANT = 3'b100
  } lbc_state_e;

endpackage

`default_nettype wire

// *** design/lbc_sync.sv ***
// Two flip-flop synchroniser for a vector of stable or slow levels
`timescale 1ns/1ns
`default_nettype none

module lbc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage is read by the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // lbc_sync

`default_nettype wire

// *** design/lbc_controller.sv ***
// Local bus controller: CPU handshake bridge with 16-bit bus sizing
//
// Summary of operation
// [RQ1] 16-bit local bus timed by local clock
// [RQ2] Burst read errors, burst write discarded
// [RQ3] CPU side waits for grant low first
// [RQ4] Read: latch address, run, then grant
// [RQ5] CPU side syncs grant, drops request
// [RQ6] Read grant drops after request withdrawn
// [RQ7] Write: latch address, grant at once
// [RQ8] CPU side hands data, then drops request
// [RQ9] Local write runs after request withdrawn
// [RQ10] Up to 64 bits split into four cycles
// [RQ11] Read strobe two local clocks after latch
// [RQ12] Ready ends strobe, captures, next address
// [RQ13] Read grant only when word assembled
// [RQ14] Write data two clocks, strobe one later
// [RQ15] Ready ends write; next request after all
// [RQ16] Ready per space: ROM 5, I/O 7
// [RQ17] Unallocated space ends by time-over
// [RQ18] Seven local clocks I/O recovery
// [RQ19] A0 low lane, upper enable high lane
// [RQ20] Expansion strobes only in expansion space
// [RQ21] Expansion ready held until strobe drops
// [RQ22] Expansion interrupt forwarded to CPU
// [RQ23] Time-over ends any long cycle
// [RQ24] Handshake inputs pass two-flop sync
`timescale 1ns/1ns
`default_nettype none
`include "lbc_regs.svh"

module lbc_controller #(
  parameter int TOUT_W = 8
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // CPU side request
  input  wire logic                 lb_request,
  input  wire logic [22:0]          cpu_addr,
  input  wire lbc_pkg::lbc_size_e   cpu_size,
  input  wire logic                 cpu_write,
  input  wire logic                 cpu_burst,
  input  wire logic [63:0]          cpu_wdata,
  // CPU side answer
  output var  logic                 lb_grant,
  output var  logic [63:0]          cpu_rdata,
  output var  logic                 cpu_bus_error,
  // Local bus clock and control inputs
  input  wire logic                 lb_clk,
  input  wire logic                 timeout_enable,
  input  wire logic                 expansion_ready,
  input  wire logic                 pci_ready,
  // Local bus address and strobes
  output var  logic [19:1]          lb_addr,
  output var  logic                 lb_a0,
  output var  logic                 upper_byte_en_n,
  output var  logic                 lb_direction,
  output var  logic                 lb_data_strobe,
  output var  logic                 ext_rd_n,
  output var  logic                 ext_wr_n,
  // Local bus data
  input  wire logic [15:0]          lb_data_in,
  output var  logic [15:0]          lb_data_out,
  output var  logic                 lb_data_oe,
  // Interrupt forwarding
  input  wire logic                 ext_int_n,
  output var  logic                 cpu_irq2_n
);

  import lbc_pkg::*;

  ////////////////////////////////////////
  // Constants

  localparam int CPU_W = 92;
  localparam int PIN_W = 21;
  localparam int TOUT_CYC = `LBC_TOUT_NS / `LBC_CLK_NS;
  localparam logic [TOUT_W-1:0] TOUT_LAST =
    TOUT_W'(TOUT_CYC - 1);

  ////////////////////////////////////////
  // Declarations

  logic [CPU_W-1:0]  cpu_s;
  logic [PIN_W-1:0]  pin_s;
  logic              req_s;
  logic [22:0]       addr_s;
  lbc_size_e         size_s;
  logic              write_s;
  logic              burst_s;
  logic [63:0]       wdata_s;
  logic              lb_clk_s;
  logic              tov_en_s;
  logic              expansion_ready_s;
  logic              prdy_s;
  logic              int_n_s;
  logic [15:0]       din_s;
  logic              lb_clk_d_reg;
  logic              lb_clk_rise;
  lbc_state_e        state_reg;
  logic [22:0]       addr_reg;
  lbc_size_e         size_reg;
  logic              burst_reg;
  logic [63:0]       wdata_reg;
  logic [1:0]        beat_reg;
  logic [2:0]        cnt_reg;
  logic [2:0]        io_rec_reg;
  logic [TOUT_W-1:0] tout_reg;
  logic [2:0]        space;
  logic              is_io;
  logic              is_ext;
  logic [2:0]        stb_at;
  logic              io_ok;
  logic              fixed_rdy;
  logic              timed_out;
  logic              cyc_done;
  logic [1:0]        last_beat;
  logic [5:0]        lane_lsb;

  ////////////////////////////////////////
  // Synchronisers

  // CPU fields are held stable while the request stands
  lbc_sync #(.W(CPU_W)) u_cpu_sync (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     ({lb_request, cpu_addr, cpu_size, cpu_write,
             cpu_burst, cpu_wdata}),
    .q     (cpu_s)
  ); // RQ24

  lbc_sync #(.W(PIN_W)) u_pin_sync (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     ({lb_clk, timeout_enable, expansion_ready,
             pci_ready, ext_int_n, lb_data_in}),
    .q     (pin_s)
  );

  assign req_s    = cpu_s[91];
  assign addr_s   = cpu_s[90:68];
  assign size_s   = lbc_size_e'(cpu_s[67:66]);
  assign write_s  = cpu_s[65];
  assign burst_s  = cpu_s[64];
  assign wdata_s  = cpu_s[63:0];
  assign lb_clk_s   = pin_s[20];
  assign tov_en_s = pin_s[19];
  assign expansion_ready_s   = pin_s[18];
  assign prdy_s   = pin_s[17];
  assign int_n_s  = pin_s[16];
  assign din_s    = pin_s[15:0];

  ////////////////////////////////////////
  // Local clock edge detect

  // Local clock is slow against mclk, so each edge is seen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lb_clk_d_reg <= 1'b0;
    end else begin
      lb_clk_d_reg <= lb_clk_s;
    end
  end

  assign lb_clk_rise = lb_clk_s & ~lb_clk_d_reg; // RQ1

  ////////////////////////////////////////
  // Decode and ready

  assign space  = addr_reg[`LBC_SP_LSB +: 3];
  assign is_io  = (space == `LBC_SP_IO);
  assign is_ext = (space == `LBC_SP_EXT);
  assign stb_at = lb_direction ? `LBC_WR_STB_AT
                               : `LBC_RD_STB_AT;
  assign io_ok  = !is_io || (io_rec_reg == 3'h0); // RQ18

  always_comb begin
    unique case (size_reg)
      SZ_8, SZ_16: last_beat = 2'h0;
      SZ_32:       last_beat = 2'h1;
      SZ_64:       last_beat = 2'h3;
    endcase
  end // RQ10

  always_comb begin
    fixed_rdy = 1'b0;
    if (space == `LBC_SP_ROM) begin
      fixed_rdy = (cnt_reg >= `LBC_ROM_WAIT);
    end else if (is_io) begin
      fixed_rdy = (cnt_reg >= `LBC_IO_WAIT);
    end else if (is_ext) begin
      fixed_rdy = expansion_ready_s;
    end else if (space == `LBC_SP_PCI) begin
      fixed_rdy = prdy_s;
    end
  end // RQ16

  // Unallocated space has no ready of its own
  assign timed_out = tov_en_s && (tout_reg == TOUT_LAST); // RQ17 RQ23
  assign cyc_done  = fixed_rdy || timed_out;
  assign lane_lsb  = {beat_reg, 4'h0};

  ////////////////////////////////////////
  // Handshake and sequencing

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      lb_grant      <= 1'b0;
      cpu_bus_error <= 1'b0;
      addr_reg      <= 23'h000000;
      size_reg      <= SZ_8;
      burst_reg     <= 1'b0;
      lb_direction  <= 1'b0;
      beat_reg      <= 2'h0;
      cnt_reg       <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // New requests only once every sized cycle is done
          if (req_s && !lb_grant) begin
            addr_reg      <= addr_s;
            size_reg      <= size_s;
            burst_reg     <= burst_s;
            lb_direction  <= write_s;
            beat_reg      <= 2'h0;
            cnt_reg       <= 3'h0;
            cpu_bus_error <= 1'b0;
            if (write_s) begin
              lb_grant  <= 1'b1;
              state_reg <= ST_WGRANT; // RQ7
            end else if (burst_s) begin
              lb_grant      <= 1'b1;
              cpu_bus_error <= 1'b1;
              state_reg     <= ST_RGRANT; // RQ2
            end else begin
              state_reg <= ST_SETUP; // RQ4
            end
          end // RQ15
        end
        ST_WGRANT: begin
          if (!req_s) begin
            lb_grant <= 1'b0;
            cnt_reg  <= 3'h0;
            // Burst writes end here with nothing driven
            state_reg <= burst_reg ? ST_IDLE : ST_SETUP; // RQ2 RQ9
          end
        end
        ST_SETUP: begin
          // Wait on I/O recovery holds the strobe back
          if (cnt_reg >= stb_at && io_ok) begin
            cnt_reg   <= 3'h0;
            state_reg <= ST_STROBE; // RQ11 RQ14 RQ18
          end else if (lb_clk_rise && cnt_reg < stb_at) begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        ST_STROBE: begin
          if (cyc_done) begin
            cnt_reg <= 3'h0;
            if (beat_reg == last_beat) begin
              if (lb_direction) begin
                state_reg <= ST_IDLE; // RQ15
              end else begin
                lb_grant  <= 1'b1;
                state_reg <= ST_RGRANT; // RQ13
              end
            end else begin
              beat_reg  <= beat_reg + 2'h1;
              addr_reg  <= addr_reg + 23'h000002;
              state_reg <= ST_SETUP; // RQ12 RQ15
            end
          end else if (lb_clk_rise && cnt_reg != 3'h7) begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        ST_RGRANT: begin
          if (!req_s) begin
            lb_grant  <= 1'b0;
            state_reg <= ST_IDLE; // RQ6
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////
  // Strobes

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lb_data_strobe <= 1'b0;
      ext_rd_n       <= 1'b1;
      ext_wr_n       <= 1'b1;
    end else if (state_reg == ST_SETUP && cnt_reg >= stb_at
                 && io_ok) begin
      lb_data_strobe <= 1'b1;
      ext_rd_n       <= !(is_ext && !lb_direction); // RQ20
      ext_wr_n       <= !(is_ext && lb_direction);
    end else if (state_reg == ST_STROBE && cyc_done) begin
      lb_data_strobe <= 1'b0; // RQ12
      ext_rd_n       <= 1'b1;
      ext_wr_n       <= 1'b1;
    end
  end

  ////////////////////////////////////////
  // Address lanes

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lb_addr         <= 19'h00000;
      lb_a0           <= 1'b0;
      upper_byte_en_n <= 1'b1;
    end else begin
      lb_addr <= addr_reg[19:1];
      lb_a0   <= addr_reg[0] && (size_reg == SZ_8); // RQ19
      // Byte access to an even address leaves the high lane off
      upper_byte_en_n <= (size_reg == SZ_8) && !addr_reg[0]; // RQ19
    end
  end

  ////////////////////////////////////////
  // Data path

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_reg <= 64'h0000000000000000;
    end else if (state_reg == ST_WGRANT && !req_s) begin
      // Data has stood since before the request dropped
      wdata_reg <= wdata_s; // RQ9
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lb_data_out <= 16'h0000;
      lb_data_oe  <= 1'b0;
    end else if (state_reg == ST_SETUP && lb_direction
                 && cnt_reg >= `LBC_WR_DATA_AT) begin
      lb_data_oe <= 1'b1; // RQ14
      if (size_reg == SZ_8) begin
        lb_data_out <= {wdata_reg[7:0], wdata_reg[7:0]};
      end else begin
        lb_data_out <= wdata_reg[lane_lsb +: `LBC_LANE_W];
      end
    end else if (state_reg != ST_STROBE) begin
      lb_data_oe <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 64'h0000000000000000;
    end else if (state_reg == ST_STROBE && cyc_done
                 && !lb_direction) begin
      if (size_reg == SZ_8) begin
        cpu_rdata[7:0] <= addr_reg[0] ? din_s[15:8]
                                      : din_s[7:0];
      end else begin
        cpu_rdata[lane_lsb +: `LBC_LANE_W] <= din_s; // RQ12 RQ1
      end
    end
  end

  ////////////////////////////////////////
  // I/O recovery

  // Counted in local clocks so it tracks the device, not mclk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      io_rec_reg <= 3'h0;
    end else if (state_reg == ST_STROBE && cyc_done && is_io) begin
      io_rec_reg <= `LBC_IO_RECOV; // RQ18
    end else if (lb_clk_rise && io_rec_reg != 3'h0) begin
      io_rec_reg <= io_rec_reg - 3'h1;
    end
  end

  ////////////////////////////////////////
  // Time-over

  // Counted in mclk; the figure is the longest, so it rounds down
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tout_reg <= '0;
    end else if (state_reg != ST_STROBE || cyc_done) begin
      tout_reg <= '0;
    end else if (tout_reg != TOUT_LAST) begin
      tout_reg <= tout_reg + TOUT_W'(1); // RQ23
    end
  end

  ////////////////////////////////////////
  // Interrupt forwarding

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_irq2_n <= `LBC_IRQ_RST;
    end else begin
      cpu_irq2_n <= int_n_s; // RQ22
    end
  end

endmodule // lbc_controller

`default_nettype wire

// *** tb/lbc_controller_chk.sv ***
// Port-level checks for the local bus controller
`timescale 1ns/1ns
`default_nettype none
`include "lbc_regs.svh"

module lbc_chk #(
  parameter int TOUT_W = 8
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // CPU side
  input wire logic        lb_request,
  input wire logic [22:0] cpu_addr,
  input wire logic        cpu_write,
  input wire logic        cpu_burst,
  input wire logic        lb_grant,
  input wire logic        cpu_bus_error,
  // Local bus
  input wire logic        timeout_enable,
  input wire logic        expansion_ready,
  input wire logic        pci_ready,
  input wire logic        lb_direction,
  input wire logic        lb_data_strobe,
  input wire logic        lb_data_oe,
  input wire logic        ext_rd_n,
  input wire logic        ext_wr_n
);
  localparam int TOUT_MAX = `LBC_TOUT_NS / `LBC_CLK_NS + 6;
  logic [9:0] stb_age_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Margin in the limit covers the enable synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stb_age_reg <= '0;
    end else if (!lb_data_strobe || !timeout_enable) begin
      stb_age_reg <= '0;
    end else if (stb_age_reg != 10'h3FF) begin
      stb_age_reg <= stb_age_reg + 10'h001;
    end
  end

  sequence s_ext_rdy;
    $rose(expansion_ready) && !(ext_rd_n && ext_wr_n);
  endsequence
  sequence s_ext_off;
    ext_rd_n && ext_wr_n;
  endsequence
  sequence s_pci_rdy;
    $rose(pci_ready) && lb_data_strobe && cpu_addr[22:20] == `LBC_SP_PCI;
  endsequence

  a_grant_dir: assert property (
    $rose(lb_grant) && !cpu_bus_error |-> lb_request && lb_direction == cpu_write)
    else $error("grant with wrong direction");
  a_grant_hold: assert property (
    lb_grant && lb_request |=> lb_grant)
    else $error("grant dropped under request");
  a_grant_drop: assert property (
    $fell(lb_request) && lb_grant |-> lb_grant ##[1:4] !lb_grant)
    else $error("grant release timing");
  a_burst_err: assert property (
    $rose(cpu_bus_error) |-> lb_grant && cpu_burst && !cpu_write && !lb_data_strobe)
    else $error("bus error without burst read");
  a_write_strobe: assert property (
    lb_data_strobe && lb_direction |-> lb_data_oe && !lb_grant)
    else $error("write strobe while granted");
  a_ext_space: assert property (
    !(ext_rd_n && ext_wr_n) |-> lb_data_strobe && cpu_addr[22:20] == `LBC_SP_EXT
      && ext_wr_n == !lb_direction)
    else $error("expansion strobe out of space");
  a_ext_ready_end: assert property (
    s_ext_rdy |-> ##[1:4] s_ext_off)
    else $error("expansion strobe outlived ready");
  a_pci_ready_end: assert property (
    s_pci_rdy |-> ##[1:4] !lb_data_strobe)
    else $error("strobe outlived pci ready");
  a_tout_bound: assert property (
    lb_data_strobe |-> stb_age_reg < TOUT_MAX)
    else $error("cycle passed time-over");
endmodule // lbc_chk

bind lbc_controller lbc_chk #(.TOUT_W(TOUT_W)) lbc_chk_i (
  .mclk, .rst_n, .lb_request, .cpu_addr, .cpu_write, .cpu_burst, .lb_grant,
  .cpu_bus_error, .timeout_enable, .expansion_ready, .pci_ready, .lb_direction,
  .lb_data_strobe, .lb_data_oe, .ext_rd_n, .ext_wr_n
);
`default_nettype wire

// *** tb/lbc_far_end.sv ***
// Local bus peripherals: expansion device, PCI controller ready, read data
`timescale 1ns/1ns
`default_nettype none
`include "lbc_regs.svh"

module lbc_far_end (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Controller outputs, and the space code from the CPU address
  input  wire logic [2:0]  space,
  input  wire logic [19:1] lb_addr,
  input  wire logic        lb_a0,
  input  wire logic        lb_data_strobe,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  // Answers
  output var  logic        expansion_ready,
  output var  logic        pci_ready,
  output var  logic [15:0] lb_data_in
);
  logic [3:0] age_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      age_reg <= '0;
    end else if (!lb_data_strobe) begin
      age_reg <= '0;
    end else if (age_reg != 4'hF) begin
      age_reg <= age_reg + 4'h1;
    end
  end

  // Ready stays up until the strobe goes away
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      expansion_ready <= 1'h0;
      pci_ready <= 1'h0;
    end else begin
      expansion_ready <= !(ext_rd_n && ext_wr_n) && age_reg >= 4'h6;
      pci_ready <= lb_data_strobe && space == `LBC_SP_PCI && age_reg >= 4'h3;
    end
  end

  // Released bus toggles, so stale data can never pass as a match
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lb_data_in <= '0;
    end else begin
      lb_data_in <= lb_data_strobe ? {lb_addr[15:1], lb_a0} ^ 16'h5A5A : ~lb_data_in;
    end
  end
endmodule // lbc_far_end
`default_nettype wire

// *** tb/tb_lbc_controller.sv ***
// Testbench for the local bus controller
`timescale 1ns/1ns
`default_nettype none
`include "lbc_regs.svh"

module tb_lbc_controller;
  import lbc_pkg::*;
  typedef struct packed {
    logic [2:0] sp; lbc_size_e sz; logic wr; logic bu; logic [19:0] a; logic [2:0] n;
  } lbc_row_s;
  logic        mclk = 1'h0, rst_n = 1'h0, lb_clk = 1'h0, lb_request = 1'h0;
  logic        cpu_write = 1'h0, cpu_burst = 1'h0, timeout_enable = 1'h1, ext_int_n = 1'h1;
  logic [22:0] cpu_addr = '0;
  lbc_size_e   cpu_size = SZ_8;
  logic [63:0] cpu_wdata = '0, cpu_rdata, got, w;
  logic        lb_grant, cpu_bus_error, expansion_ready, pci_ready, lb_a0, upper_byte_en_n;
  logic        lb_direction, lb_data_strobe, ext_rd_n, ext_wr_n, lb_data_oe, cpu_irq2_n, err;
  logic        stb_q = 1'h0, lb_clk_q = 1'h0;
  logic [19:1] lb_addr;
  logic [15:0] lb_data_in, lb_data_out;
  logic [36:0] beats[$];
  lbc_row_s    rows[12];
  int          n_errors = 0, num_checks = 0, width = 0, gap = 0, last_gap = 0, ext_n = 0;

  lbc_controller #(.TOUT_W(8)) lbc_controller_i (
    .mclk, .rst_n, .lb_request, .cpu_addr, .cpu_size, .cpu_write, .cpu_burst, .cpu_wdata,
    .lb_grant, .cpu_rdata, .cpu_bus_error, .lb_clk, .timeout_enable, .expansion_ready,
    .pci_ready, .lb_addr, .lb_a0, .upper_byte_en_n, .lb_direction, .lb_data_strobe,
    .ext_rd_n, .ext_wr_n, .lb_data_in, .lb_data_out, .lb_data_oe, .ext_int_n, .cpu_irq2_n);
  lbc_far_end lbc_far_end_i (
    .mclk, .rst_n, .space(cpu_addr[22:20]), .lb_addr, .lb_a0, .lb_data_strobe,
    .ext_rd_n, .ext_wr_n, .expansion_ready, .pci_ready, .lb_data_in);

  initial forever #20 mclk = ~mclk;
  initial begin
    #7;
    forever #160 lb_clk = ~lb_clk;
  end

  // Beat log, strobe width and gap in local clock rises
  always @(negedge mclk) begin
    if (lb_data_strobe && !stb_q) begin
      beats.push_back({upper_byte_en_n, lb_addr, lb_a0, lb_data_out});
      last_gap = gap;
      width = 0;
    end
    if (lb_clk && !lb_clk_q) begin
      if (lb_data_strobe) width++;
      else gap++;
    end
    if (!lb_data_strobe && stb_q) gap = 0;
    if (!ext_rd_n || !ext_wr_n) ext_n++;
    stb_q = lb_data_strobe;
    lb_clk_q = lb_clk;
  end

  task automatic check(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic run(input lbc_row_s r, input logic [63:0] d, input logic hang);
    int t;
    logic [19:0] ba;
    logic [63:0] e, m;
    for (t = 0; t < 3000 && lb_grant !== 1'h0; t++) @(negedge mclk);
    check(64'(t < 3000), 64'h1);
    ext_n = 0;
    @(posedge mclk);
    lb_request <= 1'h1;
    cpu_addr <= {r.sp, r.a};
    cpu_size <= r.sz;
    cpu_write <= r.wr;
    cpu_burst <= r.bu;
    cpu_wdata <= d;
    if (hang) begin
      repeat (300) @(negedge mclk);
      check(lb_data_strobe, 1'h1);
      check(lb_grant, 1'h0);
      @(posedge mclk) timeout_enable <= 1'h1;
    end
    for (t = 0; t < 3000 && lb_grant !== 1'h1; t++) @(negedge mclk);
    check(64'(t < 3000), 64'h1);
    got = cpu_rdata;
    err = cpu_bus_error;
    repeat (3) @(posedge mclk);
    lb_request <= 1'h0;
    for (t = 0; t < 3000 && (lb_grant !== 1'h0 || beats.size() < r.n || lb_data_oe !== 1'h0); t++)
      @(negedge mclk);
    check(64'(t < 3000), 64'h1);
    check(err, r.bu & ~r.wr);
    check(64'(beats.size()), 64'(r.n));
    e = '0;
    for (int k = 0; k < r.n; k++) begin
      ba = r.a + 20'(2 * k);
      e[16*k +: 16] = ba[15:0] ^ 16'h5A5A;
      check(beats[k][36:16], {r.sz == SZ_8 && !ba[0], ba});
      if (r.wr) check(beats[k][15:0], r.sz == SZ_8 ? {2{d[7:0]}} : d[16*k +: 16]);
    end
    m = r.n == 4 ? '1 : (64'h1 << (16 * r.n)) - 64'h1;
    if (r.sz == SZ_8) begin
      e = {56'h0, r.a[0] ? e[15:8] : e[7:0]};
      m = 64'hFF;
    end
    if (!r.wr && r.n > 0) check(got & m, e);
    if (r.n > 0 && r.sp == `LBC_SP_ROM) check(64'(width), 64'(`LBC_ROM_WAIT));
    if (r.n > 0 && r.sp == `LBC_SP_IO) check(64'(width), 64'(`LBC_IO_WAIT));
    if (r.n > 1 && r.sp == `LBC_SP_IO) check(last_gap >= `LBC_IO_RECOV, 1'h1);
    check(ext_n > 0, r.sp == `LBC_SP_EXT && r.n > 0);
    repeat (r.n) void'(beats.pop_front());
  endtask

  initial begin
    #(40 * 80000);
    n_errors++;
    print_verdict();
  end

  initial begin
    // Space, size, write, burst, byte address, expected beats
    rows = '{
      '{3'h0, SZ_8, 1'h0, 1'h0, 20'h00013, 3'h1}, '{3'h0, SZ_16, 1'h0, 1'h0, 20'h00100, 3'h1},
      '{3'h1, SZ_32, 1'h0, 1'h0, 20'h00220, 3'h2}, '{3'h2, SZ_64, 1'h0, 1'h0, 20'h01000, 3'h4},
      '{3'h3, SZ_32, 1'h0, 1'h0, 20'h02004, 3'h2}, '{3'h5, SZ_16, 1'h0, 1'h0, 20'h00040, 3'h1},
      '{3'h2, SZ_32, 1'h1, 1'h0, 20'h03000, 3'h2}, '{3'h0, SZ_8, 1'h1, 1'h0, 20'h00402, 3'h1},
      '{3'h3, SZ_64, 1'h1, 1'h0, 20'h04008, 3'h4}, '{3'h2, SZ_32, 1'h0, 1'h1, 20'h05000, 3'h0},
      '{3'h0, SZ_16, 1'h1, 1'h1, 20'h06000, 3'h0}, '{3'h1, SZ_32, 1'h1, 1'h0, 20'h07000, 3'h2}};
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    for (int i = 0; i < 12; i++) begin
      w = 64'hC3A5_0F1E_7788_9AB4 + 64'(i);
      run(rows[i], w, 1'h0);
      $display("row %0d done", i);
    end
    // Unallocated space hangs until time-over is switched on
    @(posedge mclk) timeout_enable <= 1'h0;
    run(lbc_row_s'{3'h6, SZ_16, 1'h0, 1'h0, 20'h00500, 3'h1}, 64'h0, 1'h1);
    $display("time-over test done");
    @(posedge mclk) ext_int_n <= 1'h0;
    repeat (4) @(negedge mclk);
    check(cpu_irq2_n, 1'h0);
    @(posedge mclk) ext_int_n <= 1'h1;
    repeat (4) @(negedge mclk);
    check(cpu_irq2_n, 1'h1);
    $display("interrupt test done");
    @(posedge mclk) rst_n <= 1'h0;
    @(negedge mclk);
    check({lb_grant, lb_data_strobe, lb_data_oe, ext_rd_n, ext_wr_n, cpu_irq2_n}, 6'h07);
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    run(rows[1], 64'h0, 1'h0);
    $display("reset test done");
    print_verdict();
  end
endmodule // tb_lbc_controller
`default_nettype wire
